// ---- logic/tbec_defs.svh ----
// Register offsets, field positions, reset values and prescaler divide
`ifndef TBEC_DEFS_SVH
`define TBEC_DEFS_SVH
`define TBEC_OFS_CTRL_SET   6'h05
`define TBEC_OFS_BUFV_CLR   6'h06
`define TBEC_OFS_EVCNT      6'h09
`define TBEC_OFS_CTRL_CLR   6'h04
`define TBEC_OFS_BUFV_SET   6'h07
`define TBEC_OFS_PERIOD_BUF 6'h26
`define TBEC_OFS_CMPBUF0    6'h38
`define TBEC_OFS_CMPBUF1    6'h3A
`define TBEC_OFS_CMPBUF2    6'h3C
`define TBEC_OFS_STATUS     6'h0B
`define TBEC_OFS_CNTL       6'h20
`define TBEC_OFS_CNTH       6'h21
`define TBEC_OFS_CTRLA      6'h00
`define TBEC_BIT_DIR        0
`define TBEC_BIT_LOCK       1
`define TBEC_CMD_LSB        2
`define TBEC_BIT_EVC_EN     0
`define TBEC_ACT_LSB        1
`define TBEC_BIT_ENABLE     0
`define TBEC_RST_CTRL       2'h0
`define TBEC_RST_BUFV       4'h0
`define TBEC_RST_EVCNT      3'h0
`define TBEC_RST_PER        16'hFFFF
`define TBEC_RST_CMP        16'h0000
`define TBEC_PRESC_DIV      8'h04
`endif

// ---- logic/tbec_pkg.sv ----
// Types shared by the timer control slice
package tbec_pkg;
  typedef enum logic [1:0] {
    tbec_cmd_none    = 2'b00,
    tbec_cmd_update  = 2'b01,
    tbec_cmd_restart = 2'b10,
    tbec_cmd_reset   = 2'b11
  } tbec_cmd_e;
  typedef enum logic [1:0] {
    count_rising_edges   = 2'b00,
    count_all_edges      = 2'b01,
    count_while_high     = 2'b10,
    event_sets_direction = 2'b11
  } tbec_evaction_e;
endpackage

// ---- logic/tbec_evt_if.sv ----
// Event-count request path between control and counter step logic
`timescale 1ns/1ps
interface tbec_evt_if;
  logic        enable;
  logic [1:0]  action;
  logic        event_sync;
  logic        presc_tick;
  logic        step;
  logic        dir_set;
  logic        dir_value;
  modport ctrl (output enable, output action, output event_sync,
                output presc_tick, input step, input dir_set,
                input dir_value);
  modport evt  (input enable, input action, input event_sync,
                input presc_tick, output step, output dir_set,
                output dir_value);
endinterface

// ---- logic/tbec_evt.sv ----
// Event action decoder: turns the event line into count steps
`timescale 1ns/1ps
module tbec_evt (
  input  wire logic mclk,
  input  wire logic rstn,
  tbec_evt_if.evt   ev
);
  import tbec_pkg::*;
  logic ev_prev;
  wire  rise     = ev.event_sync & ~ev_prev;
  wire  any_edge = ev.event_sync ^ ev_prev;
  logic step_sel;
  always_comb begin
    case (tbec_evaction_e'(ev.action))
      count_rising_edges:   step_sel = rise;
      count_all_edges:      step_sel = any_edge;
      count_while_high:     step_sel = ev.presc_tick & ev.event_sync;
      default:              step_sel = ev.presc_tick;
    endcase
  end
  assign ev.step      = ev.enable & step_sel;
  assign ev.dir_set   = ev.enable & (ev.action == 2'b11);
  assign ev.dir_value = ev.event_sync;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ev_prev <= 1'b0;
    end else begin
      ev_prev <= ev.event_sync;
    end
  end
endmodule

// ---- logic/tbec_top.sv ----
// Timer control slice: command, lock, direction, buffer valid, events
//
// Contract
// - Writing one to set view sets bit
// - Status bits read through both views
// - Command codes: none, update, restart, reset
// - Command field always reads zero
// - Hard reset command ignored while enabled
// - Lock bit blocks buffer copies on update
// - Direction bit: zero up, one down
// - Writing one to clear view clears bit
// - Compare valid sets on write, clears on update
// - Period valid sets on write, clears on update
// - Action 0 rising edges, 1 all edges
// - Action 2 counts prescaled clock while high
// - Action 3 event line selects direction
// - Event control: bit 0 enable, 2:1 action
// - Enable zero disables event counting
`timescale 1ns/1ps
`include "tbec_defs.svh"
module tbec_top #(
  parameter int CNT_W = 16
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [5:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [7:0]       rdata,
  input  wire logic             event_in,
  input  wire logic             update_cond,
  output logic      [CNT_W-1:0] count,
  output logic      [CNT_W-1:0] period,
  output logic      [CNT_W-1:0] compare0,
  output logic      [CNT_W-1:0] compare1,
  output logic      [CNT_W-1:0] compare2,
  output logic                  restart_pulse,
  output logic                  update_pulse
);
  import tbec_pkg::*;

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  logic             dir;
  logic             lock_buffer_update;
  logic [3:0]       bufv;
  logic [2:0]       event_count_control;
  logic             enable;
  logic [CNT_W-1:0] period_buffer;
  logic [CNT_W-1:0] compare_buffer [3];
  logic [7:0]       presc_cnt;
  logic [1:0]       ev_sync;
  logic [7:0]       next_rdata;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction

  wire w_set   = wr & hit(addr, `TBEC_OFS_CTRL_SET);
  wire w_clr   = wr & hit(addr, `TBEC_OFS_CTRL_CLR);
  wire w_vclr  = wr & hit(addr, `TBEC_OFS_BUFV_CLR);
  wire w_vset  = wr & hit(addr, `TBEC_OFS_BUFV_SET);
  wire w_ev    = wr & hit(addr, `TBEC_OFS_EVCNT);
  wire w_ctrla = wr & hit(addr, `TBEC_OFS_CTRLA);
  wire w_perl  = wr & hit(addr, `TBEC_OFS_PERIOD_BUF);
  wire w_perh  = wr & hit(addr, `TBEC_OFS_PERIOD_BUF + 6'h01);

  wire [1:0] cmd = wdata[`TBEC_CMD_LSB +: 2];
  wire cmd_upd = w_set & (tbec_cmd_e'(cmd) == tbec_cmd_update);
  wire cmd_rst = w_set & (tbec_cmd_e'(cmd) == tbec_cmd_restart);
  // Hard reset only takes effect while the timer is stopped
  wire cmd_is_reset = (tbec_cmd_e'(cmd) == tbec_cmd_reset);
  wire cmd_hrs = w_set & cmd_is_reset
                 & ~enable;

  wire upd_event = update_cond | cmd_upd;
  wire do_copy   = upd_event & ~lock_buffer_update;

  // ----------------------------------------
  // Event path
  // ----------------------------------------
  wire presc_tick = (presc_cnt == `TBEC_PRESC_DIV - 8'h01);
  tbec_evt_if evi ();
  wire       evc_enable = event_count_control[`TBEC_BIT_EVC_EN];
  wire [1:0] evc_action = event_count_control[`TBEC_ACT_LSB +: 2];
  assign evi.enable     = evc_enable;
  assign evi.action     = evc_action;
  assign evi.event_sync = ev_sync[1];
  assign evi.presc_tick = enable & presc_tick;
  tbec_evt u_evt (
    .mclk (mclk),
    .rstn (rstn),
    .ev   (evi)
  );

  // Two-flop synchroniser for the asynchronous event pin
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ev_sync <= 2'b00;
    end else begin
      ev_sync <= {ev_sync[0], event_in};
    end
  end

  // Divider for the prescaled count clock
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      presc_cnt <= 8'h00;
    end else if (!enable || presc_tick) begin
      presc_cnt <= 8'h00;
    end else begin
      presc_cnt <= presc_cnt + 8'h01;
    end
  end

  // ----------------------------------------
  // Control set and clear views
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {lock_buffer_update, dir} <= `TBEC_RST_CTRL;
    end else if (cmd_hrs) begin
      {lock_buffer_update, dir} <= `TBEC_RST_CTRL;
    end else begin
      if (evi.dir_set) begin
        dir <= evi.dir_value;
      end else if (w_set && wdata[`TBEC_BIT_DIR]) begin
        dir <= 1'b1;
      end else if (w_clr && wdata[`TBEC_BIT_DIR]) begin
        dir <= 1'b0;
      end
      if (w_set && wdata[`TBEC_BIT_LOCK]) begin
        lock_buffer_update <= 1'b1;
      end else if (w_clr && wdata[`TBEC_BIT_LOCK]) begin
        lock_buffer_update <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enable              <= 1'b0;
      event_count_control <= `TBEC_RST_EVCNT;
    end else begin
      if (w_ctrla) begin
        enable <= wdata[`TBEC_BIT_ENABLE];
      end
      if (w_ev) begin
        event_count_control <= wdata[2:0];
      end else if (cmd_hrs) begin
        event_count_control <= `TBEC_RST_EVCNT;
      end
    end
  end

  // ----------------------------------------
  // Buffers and valid flags
  // ----------------------------------------
  logic [3:0] buf_wr;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      wire wl = wr & hit(addr, `TBEC_OFS_CMPBUF0 + 6'(2 * gi));
      wire wh = wr & hit(addr, `TBEC_OFS_CMPBUF0 + 6'(2 * gi + 1));
      assign buf_wr[gi+1] = wl | wh;
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          compare_buffer[gi] <= `TBEC_RST_CMP;
        end else if (cmd_hrs) begin
          compare_buffer[gi] <= `TBEC_RST_CMP;
        end else if (wl) begin
          compare_buffer[gi][7:0] <= wdata;
        end else if (wh) begin
          compare_buffer[gi][15:8] <= wdata;
        end
      end
    end
  endgenerate
  assign buf_wr[0] = w_perl | w_perh;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      period_buffer <= `TBEC_RST_PER;
    end else if (cmd_hrs) begin
      period_buffer <= `TBEC_RST_PER;
    end else if (w_perl) begin
      period_buffer[7:0] <= wdata;
    end else if (w_perh) begin
      period_buffer[15:8] <= wdata;
    end
  end

  // Set by a buffer write wins over clears in the same cycle
  wire [3:0] bufv_clr = (w_vclr ? wdata[3:0] : 4'h0)
                        | {4{do_copy | cmd_hrs}};
  wire [3:0] bufv_set = buf_wr | (w_vset ? wdata[3:0] : 4'h0);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bufv <= `TBEC_RST_BUFV;
    end else begin
      bufv <= (bufv & ~bufv_clr) | bufv_set;
    end
  end

  // ----------------------------------------
  // Buffered register copy and counter
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      period   <= `TBEC_RST_PER;
      compare0 <= `TBEC_RST_CMP;
      compare1 <= `TBEC_RST_CMP;
      compare2 <= `TBEC_RST_CMP;
    end else if (cmd_hrs) begin
      period   <= `TBEC_RST_PER;
      compare0 <= `TBEC_RST_CMP;
      compare1 <= `TBEC_RST_CMP;
      compare2 <= `TBEC_RST_CMP;
    end else if (do_copy) begin
      if (bufv[0]) period <= period_buffer;
      if (bufv[1]) compare0 <= compare_buffer[0];
      if (bufv[2]) compare1 <= compare_buffer[1];
      if (bufv[3]) compare2 <= compare_buffer[2];
    end
  end

  wire plain_tick = enable & presc_tick & ~evi.enable;
  wire step       = enable & (evi.step | plain_tick);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else if (cmd_hrs || cmd_rst) begin
      count <= '0;
    end else if (w_set || w_clr) begin
      count <= count;
    end else if (step) begin
      count <= dir ? count - 1'b1 : count + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      restart_pulse <= 1'b0;
      update_pulse  <= 1'b0;
    end else begin
      restart_pulse <= cmd_rst;
      update_pulse  <= do_copy;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire [7:0] ctrl_view = {4'h0, 2'b00, lock_buffer_update, dir};
  wire rd_ctrl = hit(addr, `TBEC_OFS_CTRL_SET) | hit(addr, `TBEC_OFS_CTRL_CLR);
  wire rd_bufv = hit(addr, `TBEC_OFS_BUFV_CLR) | hit(addr, `TBEC_OFS_BUFV_SET);
  wire rd_evc  = hit(addr, `TBEC_OFS_EVCNT);
  wire rd_ena  = hit(addr, `TBEC_OFS_CTRLA);
  wire rd_cntl = hit(addr, `TBEC_OFS_CNTL);
  wire rd_cnth = hit(addr, `TBEC_OFS_CNTH);
  wire rd_perl = hit(addr, `TBEC_OFS_PERIOD_BUF);
  wire rd_perh = hit(addr, `TBEC_OFS_PERIOD_BUF + 6'h01);

  // ----------------------------------------
  // Read select
  // ----------------------------------------
  always_comb begin
    if (rd_ctrl) begin
      next_rdata = ctrl_view;
    end else if (rd_bufv) begin
      next_rdata = {4'h0, bufv};
    end else if (rd_evc) begin
      next_rdata = {5'h00, event_count_control};
    end else if (rd_ena) begin
      next_rdata = {7'h00, enable};
    end else if (rd_cntl) begin
      next_rdata = count[7:0];
    end else if (rd_cnth) begin
      next_rdata = count[15:8];
    end else if (rd_perl) begin
      next_rdata = period_buffer[7:0];
    end else if (rd_perh) begin
      next_rdata = period_buffer[15:8];
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// ---- sim/tbec_top_checker.sv ----
// Port checker for the timer control slice
`timescale 1ns/1ps
module tbec_top_checker #(
  parameter int CNT_W = 16
) (
  input wire logic             mclk,
  input wire logic             rstn,
  input wire logic [5:0]       addr,
  input wire logic [7:0]       wdata,
  input wire logic             wr,
  input wire logic             rd,
  input wire logic [7:0]       rdata,
  input wire logic             event_in,
  input wire logic             update_cond,
  input wire logic [CNT_W-1:0] count,
  input wire logic [CNT_W-1:0] period,
  input wire logic [CNT_W-1:0] compare0,
  input wire logic [CNT_W-1:0] compare1,
  input wire logic [CNT_W-1:0] compare2,
  input wire logic             restart_pulse,
  input wire logic             update_pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Register view and pulse checks
  // ----------------------------------------
  a_cmd_reads_zero:
    assert property (rd && addr[5:1] == 5'h02 |=> rdata[3:2] == 2'h0)
      else $error("command bits read back");
  a_set_both_views:
    assert property (wr && addr == 6'h05 && wdata[1] && wdata[3:2] != 2'h3
      ##1 rd && addr == 6'h04 |=> rdata[1]) else $error("lock not set");
  a_clear_lock_bit:
    assert property (wr && addr == 6'h04 && wdata[1]
      ##1 rd && addr == 6'h05 |=> !rdata[1]) else $error("lock not cleared");
  a_valid_cleared:
    assert property (wr && addr == 6'h06 && wdata[3:0] == 4'hF
      ##1 rd && addr == 6'h06 |=> rdata[3:0] == 4'h0)
      else $error("valid flags stay");
  a_period_valid:
    assert property (wr && addr == 6'h26 ##1 rd && addr == 6'h06
      |=> rdata[0]) else $error("period flag not set");
  a_compare_valid:
    assert property (wr && addr == 6'h38 ##1 rd && addr == 6'h06
      |=> rdata[1]) else $error("compare flag not set");
  a_evcount_readback:
    assert property (wr && addr == 6'h09 ##1 rd && addr == 6'h09
      |=> rdata[2:0] == $past(wdata[2:0], 2))
      else $error("event control read");
  a_restart_pulse:
    assert property (wr && addr == 6'h05 && wdata[3:2] == 2'h2
      |=> restart_pulse) else $error("no restart pulse");
  a_locked_no_copy:
    assert property (wr && addr == 6'h05 && wdata[3:1] == 3'h1
      ##1 update_cond |=> !update_pulse) else $error("copy while locked");
  c_update: cover property (update_pulse);
  c_restart: cover property (restart_pulse);
  c_valid_read: cover property (rd && addr == 6'h06);
endmodule

// ---- sim/tbec_evnet.sv ----
// Event network model feeding the timer event input
`timescale 1ns/1ps
module tbec_evnet (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic req,
  output logic      event_in
);
  // Routing stage delays the requested level one clock
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      event_in <= 1'b0;
    end else begin
      event_in <= req;
    end
  end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the timer control slice
`timescale 1ns/1ps
module testbench;
  logic        mclk, rstn, wr, rd, update_cond, ev_req, event_in;
  logic        restart_pulse, update_pulse;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [15:0] count, period, compare0, compare1, compare2, p, c, c0;
  int          bad_count, comparisons, cyc, n;
  tbec_top dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .event_in(event_in),
    .update_cond(update_cond), .count(count), .period(period),
    .compare0(compare0), .compare1(compare1), .compare2(compare2),
    .restart_pulse(restart_pulse), .update_pulse(update_pulse));
  tbec_evnet u_ev (.mclk(mclk), .rstn(rstn), .req(ev_req),
    .event_in(event_in));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic drive(input logic w, r, u, input logic [5:0] a,
                       input logic [7:0] d);
    wr <= w;
    rd <= r;
    update_cond <= u;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    drive(1'b1, 1'b0, 1'b0, a, d);
  endtask
  task automatic rd_reg(input logic [5:0] a, input logic [7:0] e);
    drive(1'b0, 1'b1, 1'b0, a, 8'h00);
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic idle(input int k);
    repeat (k) drive(1'b0, 1'b0, 1'b0, 6'h00, 8'h00);
  endtask
  task automatic rng(input logic [15:0] d);
    chk({15'h0000, d > 16'h0007 && d < 16'h000D}, 16'h0001);
  endtask
  function automatic int steps(input int act, input int k);
    return (act == 1) ? 2 * k : k;
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h8C27643C));
    mclk = 1'b0; rstn = 1'b0; wr = 1'b0; rd = 1'b0; update_cond = 1'b0;
    addr = 6'h00; wdata = 8'h00; ev_req = 1'b0;
    bad_count = 0; comparisons = 0; cyc = 0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk(count, 16'h0000);
    rd_reg(6'h05, 8'h00);
    rd_reg(6'h06, 8'h00);
    rd_reg(6'h09, 8'h00);
    wr_reg(6'h05, 8'h03);
    rd_reg(6'h04, 8'h03);
    wr_reg(6'h04, 8'h01);
    rd_reg(6'h05, 8'h02);
    for (int k = 0; k < 3; k++) begin
      wr_reg(6'h05, 8'(k << 2));
      chk({15'h0000, restart_pulse}, 16'(k == 2));
      rd_reg(6'h05, 8'h02);
    end
    wr_reg(6'h00, 8'h01);
    wr_reg(6'h05, 8'h0C);
    rd_reg(6'h05, 8'h02);
    wr_reg(6'h00, 8'h00);
    wr_reg(6'h05, 8'h0C);
    rd_reg(6'h05, 8'h00);
    p = 16'($urandom);
    c = 16'($urandom);
    wr_reg(6'h26, p[7:0]);
    rd_reg(6'h06, 8'h01);
    wr_reg(6'h27, p[15:8]);
    wr_reg(6'h3C, c[7:0]);
    wr_reg(6'h3A, c[7:0]);
    wr_reg(6'h39, c[15:8]);
    wr_reg(6'h38, c[7:0]);
    rd_reg(6'h06, 8'h0F);
    wr_reg(6'h06, 8'h05);
    rd_reg(6'h06, 8'h0A);
    wr_reg(6'h05, 8'h02);
    drive(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
    chk({15'h0000, update_pulse}, 16'h0000);
    rd_reg(6'h06, 8'h0A);
    chk(compare0, 16'h0000);
    wr_reg(6'h04, 8'h02);
    rd_reg(6'h05, 8'h00);
    drive(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
    chk({15'h0000, update_pulse}, 16'h0001);
    chk(compare0, c);
    chk(period, 16'hFFFF);
    chk(compare1, 16'h0000);
    chk(compare2, {8'h00, c[7:0]});
    wr_reg(6'h3B, c[15:8]);
    wr_reg(6'h06, 8'h0F);
    rd_reg(6'h06, 8'h00);
    wr_reg(6'h07, 8'h09);
    rd_reg(6'h07, 8'h09);
    wr_reg(6'h05, 8'h04);
    chk({15'h0000, update_pulse}, 16'h0001);
    chk(period, p);
    rd_reg(6'h06, 8'h00);
    wr_reg(6'h00, 8'h01);
    for (int a = 0; a < 2; a++) begin
      n = $urandom_range(8, 1);
      wr_reg(6'h09, 8'(2 * a + 1));
      idle(4);
      c0 = count;
      repeat (n) begin
        ev_req <= 1'b1;
        idle(6);
        ev_req <= 1'b0;
        idle(6);
      end
      idle(4);
      chk(count - c0, 16'(steps(a, n)));
    end
    wr_reg(6'h09, 8'h05);
    rd_reg(6'h09, 8'h05);
    idle(4);
    c0 = count;
    idle(40);
    chk(count, c0);
    ev_req <= 1'b1;
    idle(44);
    rng(count - c0);
    ev_req <= 1'b0;
    wr_reg(6'h09, 8'h04);
    idle(4);
    c0 = count;
    idle(40);
    rng(count - c0);
    wr_reg(6'h05, 8'h01);
    idle(4);
    c0 = count;
    idle(40);
    rng(c0 - count);
    wr_reg(6'h09, 8'h07);
    idle(4);
    c0 = count;
    idle(40);
    rng(count - c0);
    ev_req <= 1'b1;
    idle(6);
    c0 = count;
    idle(40);
    rng(c0 - count);
    final_report();
  end
endmodule
bind tbec_top tbec_top_checker #(.CNT_W(CNT_W)) u_chk (.mclk(mclk),
  .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .event_in(event_in), .update_cond(update_cond),
  .count(count), .period(period), .compare0(compare0),
  .compare1(compare1), .compare2(compare2),
  .restart_pulse(restart_pulse), .update_pulse(update_pulse));
